// ===== src/dmr_params.svh
// timing and field constants for the operating mode register block
// assumes inclusion from the package and the design module
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH
`define DMR_BL_LSB        0
`define DMR_CL_LO_BIT     2
`define DMR_ORDER_BIT     3
`define DMR_CL_HI_LSB     4
`define DMR_TEST_BIT      7
`define DMR_DLL_RST_BIT   8
`define DMR_WR_LSB        9
`define DMR_PD_BIT        12
`define DMR_CHOP_SEL_BIT  12
`define DMR_BL_FIXED8     2'h0
`define DMR_BL_OTF        2'h1
`define DMR_BL_FIXED4     2'h2
`define DMR_CHOP_PULLIN   5'h02
`define DMR_BEATS         4'h8
`endif

// ===== src/dmr_pkg.sv
// types for the operating mode register block
// assumes dmr_params.svh is reachable by bare name
`include "dmr_params.svh"
package dmr_pkg;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] bank;
		logic [15:0] addr;
	} dmr_cmd_t;
	typedef struct packed {
		logic [1:0] burst_size_select;
		logic       burst_order_kind;
		logic [4:0] read_column_latency;
		logic       vendor_test_select;
		logic [4:0] store_recovery_time;
		logic       powerdown_exit_speed;
		logic       fields_valid;
	} dmr_cfg_t;
	typedef enum logic [1:0] {DMR_IDLE, DMR_RD, DMR_WR} dmr_burst_t;
endpackage

// ===== src/dmr_mode_register.sv
// operating mode register: decode, burst column order, write timing shift
// assumes command pins already sampled on ref_clk rising edges
`timescale 1ns/100ps
`include "dmr_params.svh"
module dmr_mode_register
	import dmr_pkg::*;
#(
	parameter int ROW_CLOSE_CYCLES = 11
) (
	// clock and control
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// command pins
	input  wire dmr_cmd_t   cmd,
	// decoded fields
	output dmr_cfg_t        cfg_q,
	output logic            dll_reset_req_q,
	output logic [5:0]      autoprecharge_total_delay_q,
	// burst column sequencing
	output logic [2:0]      beat_column_q,
	output logic            beat_valid_q,
	output logic            data_drive_q,
	output logic            chopped_four_beat_q,
	output logic [4:0]      store_pullin_q
);
	////////////////////////////////////////////////////////////////
	logic        mrs_hit;
	logic        rd_hit;
	logic        wr_hit;
	logic [15:0] a;
	dmr_burst_t  kind_q;
	logic [2:0]  start_q;
	logic [3:0]  beat_q;
	logic        order_q;
	logic        chop_now;

	assign a       = cmd.addr;
	assign mrs_hit = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n
		&& (cmd.bank == 3'h0);
	assign rd_hit  = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
	assign wr_hit  = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n;

	// chop decision for the command on the pins; reserved size falls back to eight
	always_comb begin
		unique case (cfg_q.burst_size_select)
			`DMR_BL_OTF:    chop_now = !a[`DMR_CHOP_SEL_BIT];
			`DMR_BL_FIXED4: chop_now = 1'b1;
			default:        chop_now = 1'b0;
		endcase
	end

	// latency decode; reserved codes give zero
	function automatic logic [4:0] cl_decode(input logic [2:0] hi, input logic lo);
		logic [4:0] v;
		v = 5'h00;
		if (!lo && hi != 3'h0)
			v = 5'(hi) + 5'h04;
		else if (lo && hi <= 3'h2)
			v = 5'(hi) + 5'h0C;
		return v;
	endfunction

	function automatic logic [4:0] wr_decode(input logic [2:0] c);
		logic [4:0] v;
		v = 5'h00;
		unique case (c)
			3'h0: v = 5'h00;
			3'h1: v = 5'h05;
			3'h2: v = 5'h06;
			3'h3: v = 5'h07;
			3'h4: v = 5'h08;
			3'h5: v = 5'h0A;
			3'h6: v = 5'h0C;
			3'h7: v = 5'h0E;
		endcase
		return v;
	endfunction

	// column for beat i: sequential wraps in nibble, interleaved xors
	function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] i,
		input logic il);
		logic [2:0] v;
		v = il ? (s ^ i) : {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
		return v;
	endfunction

	////////////////////////////////////////////////////////////////
	// register capture; reset clears every field to zero until the first write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_q <= '0;
		end else if (clk_en && mrs_hit) begin
			cfg_q.burst_size_select    <= a[`DMR_BL_LSB +: 2];
			cfg_q.burst_order_kind     <= a[`DMR_ORDER_BIT];
			cfg_q.read_column_latency  <= cl_decode(a[`DMR_CL_HI_LSB +: 3],
				a[`DMR_CL_LO_BIT]);
			cfg_q.vendor_test_select   <= a[`DMR_TEST_BIT];
			cfg_q.store_recovery_time  <= wr_decode(a[`DMR_WR_LSB +: 3]);
			cfg_q.powerdown_exit_speed <= a[`DMR_PD_BIT];
			cfg_q.fields_valid         <= 1'b1;
		end
	end

	// loop reset request is a self-clearing pulse
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			dll_reset_req_q <= 1'b0;
		else if (clk_en)
			dll_reset_req_q <= mrs_hit && a[`DMR_DLL_RST_BIT];
	end

	// recovery plus row close time
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			autoprecharge_total_delay_q <= '0;
		else if (clk_en)
			autoprecharge_total_delay_q <= 6'(cfg_q.store_recovery_time)
				+ 6'(ROW_CLOSE_CYCLES);
	end

	////////////////////////////////////////////////////////////////
	// burst sequencer: a new command restarts the burst
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			kind_q              <= DMR_IDLE;
			start_q             <= 3'h0;
			beat_q              <= 4'h0;
			order_q             <= 1'b0;
			chopped_four_beat_q <= 1'b0;
			store_pullin_q      <= 5'h00;
		end else if (clk_en) begin
			if (rd_hit || wr_hit) begin
				kind_q  <= rd_hit ? DMR_RD : DMR_WR;
				beat_q  <= 4'h0;
				order_q <= cfg_q.burst_order_kind;
				chopped_four_beat_q <= chop_now;
				// fixed chop pulls write in, per-command chop does not
				store_pullin_q <= (wr_hit && cfg_q.burst_size_select == `DMR_BL_FIXED4)
					? `DMR_CHOP_PULLIN : 5'h00;
				if (rd_hit)
					start_q <= a[2:0];
				else if (chop_now)
					start_q <= {a[2], 2'h0};
				else
					start_q <= 3'h0;
			end else if (kind_q != DMR_IDLE) begin
				if (beat_q == `DMR_BEATS - 4'h1)
					kind_q <= DMR_IDLE;
				beat_q <= beat_q + 4'h1;
			end
		end
	end

	// per-beat column and output drive
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			beat_column_q <= 3'h0;
			beat_valid_q  <= 1'b0;
			data_drive_q  <= 1'b0;
		end else if (clk_en) begin
			beat_valid_q <= kind_q != DMR_IDLE && !(chopped_four_beat_q && beat_q[2]);
			data_drive_q <= kind_q == DMR_RD && !(chopped_four_beat_q && beat_q[2]);
			if (kind_q == DMR_WR)
				beat_column_q <= start_q + beat_q[2:0];
			else
				beat_column_q <= col_of(start_q, beat_q[2:0], order_q);
		end
	end

	////////////////////////////////////////////////////////////////
	property p_mrs_dll;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit && a[`DMR_DLL_RST_BIT] |=> dll_reset_req_q;
	endproperty
	a_mrs_dll: assert property (p_mrs_dll) else $error("loop reset pulse wrong");

	property p_bl_decode;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit |=> cfg_q.burst_size_select == $past(a[1:0]);
	endproperty
	a_bl_decode: assert property (p_bl_decode) else $error("burst size not captured");

	property p_no_capture;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !mrs_hit |=> $stable(cfg_q);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("register changed");

	property p_cl_range;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit && !a[2] && a[6:4] == 3'h1 |=> cfg_q.read_column_latency == 5'h05;
	endproperty
	a_cl_range: assert property (p_cl_range) else $error("latency decode");

	property p_wr_map;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit && a[11:9] == 3'h5 |=> cfg_q.store_recovery_time == 5'h0A;
	endproperty
	a_wr_map: assert property (p_wr_map) else $error("recovery decode");

	property p_autoprecharge_total_delay;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && $past(clk_en) && $past(rst_n) |-> autoprecharge_total_delay_q ==
			6'($past(cfg_q.store_recovery_time)) + 6'(ROW_CLOSE_CYCLES);
	endproperty
	a_autoprecharge_total_delay: assert property (p_autoprecharge_total_delay) else $error("total delay wrong");

	property p_pullin;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_hit && cfg_q.burst_size_select == `DMR_BL_OTF |=> store_pullin_q == 5'h00;
	endproperty
	a_pullin: assert property (p_pullin) else $error("per-command chop pulled in");

	property p_fixed4;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_hit && cfg_q.burst_size_select == `DMR_BL_FIXED4
			|=> store_pullin_q == 5'h02 && chopped_four_beat_q;
	endproperty
	a_fixed4: assert property (p_fixed4) else $error("fixed chop timing");

	property p_pd;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit |=> cfg_q.powerdown_exit_speed == $past(a[12])
			&& cfg_q.vendor_test_select == $past(a[7]);
	endproperty
	a_pd: assert property (p_pd) else $error("exit or test bit");

	property p_chop_otf;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_hit && cfg_q.burst_size_select == `DMR_BL_OTF
			|=> chopped_four_beat_q == !$past(a[12]);
	endproperty
	a_chop_otf: assert property (p_chop_otf) else $error("chop select");

	property p_dll_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !(mrs_hit && a[`DMR_DLL_RST_BIT]) |=> !dll_reset_req_q;
	endproperty
	a_dll_clear: assert property (p_dll_clear) else $error("loop reset request stuck");

	property p_cl_high;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mrs_hit && a[2] && a[6:4] == 3'h2 |=> cfg_q.read_column_latency == 5'h0E;
	endproperty
	a_cl_high: assert property (p_cl_high) else $error("upper latency decode");

	property p_read_start;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_hit |=> start_q == $past(a[2:0]);
	endproperty
	a_read_start: assert property (p_read_start) else $error("read start column");

	property p_write_start8;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_hit && cfg_q.burst_size_select == `DMR_BL_FIXED8 |=> start_q == 3'h0;
	endproperty
	a_write_start8: assert property (p_write_start8) else $error("eight-beat write start");

	property p_chop_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && chopped_four_beat_q && beat_q[2] |=> !beat_valid_q && !data_drive_q;
	endproperty
	a_chop_quiet: assert property (p_chop_quiet) else $error("chop drove a late slot");

	property p_write_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && kind_q == DMR_WR |=> !data_drive_q;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("write drove data");

	property p_burst_end;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && kind_q != DMR_IDLE && beat_q == 4'h7 && !rd_hit && !wr_hit
			|=> kind_q == DMR_IDLE;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst overran eight slots");

	property p_read_pullin;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_hit |=> store_pullin_q == 5'h00;
	endproperty
	a_read_pullin: assert property (p_read_pullin) else $error("read pulled in");

	property p_fixed8_chop;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && (rd_hit || wr_hit) && cfg_q.burst_size_select == `DMR_BL_FIXED8
			|=> !chopped_four_beat_q;
	endproperty
	a_fixed8_chop: assert property (p_fixed8_chop) else $error("fixed eight chopped");
endmodule

// ===== verification/dmr_ctrl_model.sv
// controller model: drives the command pins for mode writes and accesses
// assumes the bench calls its tasks; pins change on falling edges only
`timescale 1ns/100ps
module dmr_ctrl_model
	import dmr_pkg::*;
(
	// clock
	input  wire logic ref_clk,
	// command pins
	output dmr_cmd_t  cmd
);
	// lowest recovery code allowed; stands for the rounded-up minimum
	localparam logic [2:0] RECOVERY_FLOOR = 3'h1;
	initial cmd = {4'hF, 3'h7, 16'h0000};
	////////////////////////////////////////////////////////////////////////
	task automatic issue(input logic [3:0] pins, input logic [15:0] a);
		@(negedge ref_clk);
		cmd = {pins, 3'h0, a};
		@(negedge ref_clk);
		// deselected: show the inverse so a stale value never passes
		cmd = {4'hF, 3'h7, ~a};
	endtask
	// every field is rewritten, a recovery code below RECOVERY_FLOOR is raised to it
	task automatic mode_write(input logic [1:0] bl, input logic ord, input logic [3:0] clc,
		input logic [2:0] wrc, input logic dll, input logic pd);
		if (wrc < RECOVERY_FLOOR) wrc = RECOVERY_FLOOR;
		issue(4'h0, {3'h0, pd, wrc, dll, 1'b0, clc[3:1], ord, clc[0], bl});
	endtask
	task automatic access(input logic rd, input logic chop_n, input logic [2:0] col);
		issue(rd ? 4'h5 : 4'h4, {3'h0, chop_n, 9'h000, col});
	endtask
endmodule

// ===== verification/dmr_mode_register_tb.sv
// bench for the operating mode register: mode writes and burst sequencing
// assumes the design and the controller model; no other stimulus source
`timescale 1ns/100ps
module dmr_mode_register_tb
	import dmr_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clk_en = 1'b1;
	dmr_cmd_t   cmd;
	dmr_cfg_t   cfg_q;
	logic       dll_reset_req_q, beat_valid_q, data_drive_q, chopped_four_beat_q;
	logic [5:0] autoprecharge_total_delay_q;
	logic [2:0] beat_column_q;
	logic [4:0] store_pullin_q;
	int         bad_count = 0;
	int         check_count = 0;
	int         dll_count = 0;
	logic [4:0] wr_tab [8] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
	always #10 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (dll_reset_req_q === 1'b1) dll_count++;
	dmr_mode_register dmr_mode_register_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.cmd(cmd), .cfg_q(cfg_q), .dll_reset_req_q(dll_reset_req_q),
		.autoprecharge_total_delay_q(autoprecharge_total_delay_q),
		.beat_column_q(beat_column_q), .beat_valid_q(beat_valid_q), .data_drive_q(data_drive_q),
		.chopped_four_beat_q(chopped_four_beat_q), .store_pullin_q(store_pullin_q));
	dmr_ctrl_model dmr_ctrl_model_i (.ref_clk(ref_clk), .cmd(cmd));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// nine slots: eight beats (four when chopped) and the idle slots after them
	task automatic burst(input logic rd, input logic chop, input logic [2:0] col,
		input logic ord, input logic [4:0] pull);
		logic [2:0] e;
		logic       v;
		dmr_ctrl_model_i.access(rd, ~chop, col);
		for (int k = 0; k < 9; k++) begin
			@(negedge ref_clk);
			e = !rd ? (chop ? {col[2], 2'h0} + 3'(k) : 3'(k)) : ord ? col ^ 3'(k)
				: {col[2] ^ k[2], col[1:0] + k[1:0]};
			v = k < (chop ? 4 : 8);
			check("valid", beat_valid_q, v);
			if (v) check("column", beat_column_q, e);
			check("drive", data_drive_q, v & rd);
			if (k == 0) check("pullin", store_pullin_q, pull);
			if (k == 0) check("chop", chopped_four_beat_q, chop);
		end
	endtask
	task automatic mode(input logic [1:0] bl, input logic ord);
		dmr_ctrl_model_i.mode_write(bl, ord, 4'h2, 3'h1, 1'b0, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
	initial begin
		logic [3:0] clc;
		repeat (2) @(negedge ref_clk);
		check("valid_rst", cfg_q.fields_valid, 8'h00);
		rst_n = 1'b1;
		// every latency and recovery codes 1 to 7, all three burst sizes
		for (int i = 0; i < 10; i++) begin
			clc = (i < 7) ? {3'(i + 1), 1'b0} : {3'(i - 7), 1'b1};
			dmr_ctrl_model_i.mode_write(2'(i % 3), i[0], clc, 3'(i % 7 + 1), i < 2, i[1]);
			repeat (2) @(negedge ref_clk);
			check("size", cfg_q.burst_size_select, i % 3);
			check("order", cfg_q.burst_order_kind, i[0]);
			check("latency", cfg_q.read_column_latency, 5 + i);
			check("recovery", cfg_q.store_recovery_time, wr_tab[i % 7 + 1]);
			check("pd_exit", cfg_q.powerdown_exit_speed, i[1]);
			check("test", cfg_q.vendor_test_select, 8'h00);
			check("valid", cfg_q.fields_valid, 8'h01);
			@(negedge ref_clk);
			check("total", autoprecharge_total_delay_q, wr_tab[i % 7 + 1] + 11);
		end
		check("dll_pulses", dll_count, 8'h02);
		mode(2'h0, 1'b0);
		burst(1'b1, 1'b0, 3'h5, 1'b0, 5'h00);
		burst(1'b0, 1'b0, 3'h5, 1'b0, 5'h00);
		mode(2'h0, 1'b1);
		burst(1'b1, 1'b0, 3'h3, 1'b1, 5'h00);
		mode(2'h2, 1'b0);
		burst(1'b1, 1'b1, 3'h6, 1'b0, 5'h00);
		burst(1'b0, 1'b1, 3'h7, 1'b0, 5'h02);
		mode(2'h2, 1'b1);
		burst(1'b1, 1'b1, 3'h5, 1'b1, 5'h00);
		mode(2'h1, 1'b0);
		burst(1'b1, 1'b1, 3'h3, 1'b0, 5'h00);
		burst(1'b1, 1'b0, 3'h1, 1'b0, 5'h00);
		burst(1'b0, 1'b1, 3'h6, 1'b0, 5'h00);
		// a frozen clock enable must swallow a mode write
		clk_en = 1'b0;
		mode(2'h2, 1'b1);
		clk_en = 1'b1;
		@(negedge ref_clk);
		check("frozen", cfg_q.burst_size_select, 8'h01);
		// a reset in mid-run clears the register until the next write
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("valid_rst", cfg_q.fields_valid, 8'h00);
		check("dll_rst", dll_reset_req_q, 8'h00);
		rst_n = 1'b1;
		mode(2'h2, 1'b0);
		@(negedge ref_clk);
		check("size_rst", cfg_q.burst_size_select, 8'h02);
		conclude();
	end
endmodule
